/* hdl/smc_ctrl.sv */
// Standby mode controller top: APB registers, mode sequencing, clock gating,
// regulator, pin and flash power policy.
// Assumes interrupt, flash-busy and external reset inputs come from other clock
// domains or pins and are synchronised here.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
module smc_ctrl (
   input  wire logic               CLK,           // 20 MHz system clock.
   input  wire logic               RST_B,         // Asynchronous reset, active low.
   input  wire logic               EXT_RST_B,     // External reset pin, active low.
   input  wire logic               IRQ_WAKE,      // Qualifying interrupt or NMI pending.
   input  wire logic               FLASH_BUSY,    // Flash program or erase ongoing.
   input  wire logic               FLASH_READY,   // Flash reached read state.
   input  wire logic               PSEL,          // APB select.
   input  wire logic               PENABLE,       // APB enable.
   input  wire logic               PWRITE,        // APB direction.
   input  wire logic [11:0]        PADDR,         // APB byte address.
   input  wire logic [31:0]        PWDATA,        // APB write data.
   output logic [31:0]             PRDATA,        // APB read data.
   output logic                    PREADY,        // APB ready.
   output logic                    PSLVERR,       // APB error for unmapped address.
   output smc_pkg::smc_clk_type    CLK_CTRL,      // Clock and oscillator enables.
   output smc_pkg::smc_pwr_type    PWR_CTRL,      // Power, pin and flash policy.
   output logic                    CORE_BUS_HOLD  // Holds the first core transfer.
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef enum {M_RUN, M_SLEEP, M_TIMER, M_STOP, M_WAKE} smc_mode_type;

   typedef struct packed {
      logic [1:0]  ext_sync;
      logic [1:0]  irq_sync;
      logic [1:0]  fbusy_sync;
      logic [1:0]  frdy_sync;
      logic        low_power_in_standby;
      logic        pin_state_select;
      logic [1:0]  standby_request;
      logic        flash_powerdown_select;
      logic [3:0]  bus_start_delay;
      logic [1:0]  system_clock1_select;
      logic [1:0]  system_clock2_select;
      logic        rc_osc_enable;
      logic        pll_enable;
      logic        main_osc_enable;
      logic        sub_osc_enable;
      logic [1:0]  system_clock1_monitor;
      logic [2:0]  mode;
      logic        flash_down;
      logic [31:0] rdata;
   } smc_state_type;

   smc_state_type st_r;
   smc_state_type st_nxt;
   smc_mode_type  mode_q;
   logic          dly_start;
   logic          dly_busy;
   logic          ext_rst;
   logic          wake;
   logic          wr_acc;
   logic          rd_acc;
   logic          addr_ok;

   // Decodes the bus start delay code into bus clock cycles.
   function automatic logic [11:0] bsd_cycles(input logic [3:0] code);
      begin
         if (code[3])
         begin
            bsd_cycles = smc_pkg::BSD_CYCLES_MAX;
         end
         else if (code == 4'h0)
         begin
            bsd_cycles = 12'h000;
         end
         else
         begin
            bsd_cycles = 12'(12'h008 << code[2:0]);
         end
      end
   endfunction : bsd_cycles

   // Reports whether a mapped register offset is addressed.
   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
      begin
         is_reg = (a == ofs);
      end
   endfunction : is_reg

   assign mode_q  = smc_mode_type'(st_r.mode);
   assign ext_rst = !st_r.ext_sync[1];
   assign wake    = st_r.irq_sync[1];
   assign wr_acc  = PSEL && PENABLE && PWRITE;
   assign rd_acc  = PSEL && !PENABLE && !PWRITE;
   assign addr_ok = is_reg(PADDR, smc_pkg::STANDBY_MODE_CONTROL_OFS)
                    || is_reg(PADDR, smc_pkg::EXTENDED_STANDBY_CONTROL_OFS)
                    || is_reg(PADDR, smc_pkg::CLOCK_SELECT_OFS)
                    || is_reg(PADDR, smc_pkg::CLOCK_MONITOR_OFS);

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   // Register writes, the mode sequencer and read data all meet here so that a
   // wake and a software write in one cycle resolve in one place.
   always_comb
   begin
      st_nxt            = st_r;
      dly_start         = 1'b0;
      st_nxt.ext_sync   = {st_r.ext_sync[0], EXT_RST_B};
      st_nxt.irq_sync   = {st_r.irq_sync[0], IRQ_WAKE};
      st_nxt.fbusy_sync = {st_r.fbusy_sync[0], FLASH_BUSY};
      st_nxt.frdy_sync  = {st_r.frdy_sync[0], FLASH_READY};

      // Register writes take effect at the access edge.
      if (wr_acc)
      begin
         if (is_reg(PADDR, smc_pkg::STANDBY_MODE_CONTROL_OFS))
         begin
            st_nxt.low_power_in_standby = PWDATA[smc_pkg::LPSS_BIT];
            st_nxt.pin_state_select     = PWDATA[smc_pkg::PSS_BIT];
            // A write while an interrupt is pending has no effect on the field.
            if (st_r.standby_request == smc_pkg::REQ_RUN && !wake)
            begin
               st_nxt.standby_request = PWDATA[1:0];
            end
         end
         if (is_reg(PADDR, smc_pkg::EXTENDED_STANDBY_CONTROL_OFS))
         begin
            st_nxt.flash_powerdown_select = PWDATA[smc_pkg::FPD_BIT];
            st_nxt.bus_start_delay        = PWDATA[3:0];
         end
         // Clock selects only change with no request pending.
         if (is_reg(PADDR, smc_pkg::CLOCK_SELECT_OFS) && st_r.standby_request == smc_pkg::REQ_RUN)
         begin
            st_nxt.system_clock1_select = PWDATA[1:0];
            st_nxt.system_clock2_select = PWDATA[smc_pkg::SC2_LSB +: 2];
            st_nxt.sub_osc_enable       = PWDATA[smc_pkg::SCE_BIT];
            st_nxt.main_osc_enable      = PWDATA[smc_pkg::MCE_BIT];
            st_nxt.pll_enable           = PWDATA[smc_pkg::PCE_BIT];
            st_nxt.rc_osc_enable        = PWDATA[smc_pkg::RCE_BIT];
         end
      end

      // Mode sequencer.
      case (mode_q)
         M_RUN:
         begin
            st_nxt.system_clock1_monitor = st_r.system_clock1_select;
            if (st_r.standby_request != smc_pkg::REQ_RUN && !wake)
            begin
               st_nxt.flash_down = st_r.flash_powerdown_select && !st_r.fbusy_sync[1];
               case (smc_pkg::smc_req_type'(st_r.standby_request))
                  smc_pkg::REQ_SLEEP: st_nxt.mode = 3'(M_SLEEP);
                  smc_pkg::REQ_TIMER: st_nxt.mode = 3'(M_TIMER);
                  default:            st_nxt.mode = 3'(M_STOP);
               endcase
            end
         end
         M_SLEEP, M_TIMER:
         begin
            if (wake)
            begin
               st_nxt.mode = 3'(M_WAKE);
            end
         end
         M_STOP:
         begin
            if (wake)
            begin
               st_nxt.system_clock1_monitor = st_r.system_clock1_select;
               st_nxt.mode                  = 3'(M_WAKE);
            end
         end
         M_WAKE:
         begin
            // Wait for the flash to reach its read state before restarting.
            if (!st_r.flash_down || st_r.frdy_sync[1])
            begin
               st_nxt.flash_down = 1'b0;
               st_nxt.mode       = 3'(M_RUN);
               dly_start         = 1'b1;
            end
         end
         default:
         begin
            st_nxt.mode = 3'(M_RUN);
         end
      endcase

      // The request clears on wake or on entering standby; the clear wins
      // over a new write in that cycle so a wake is never missed.
      if (wake || (mode_q == M_RUN && st_r.standby_request != smc_pkg::REQ_RUN))
      begin
         st_nxt.standby_request = smc_pkg::REQ_RUN;
      end

      // Read data, captured in the setup cycle; undefined bits read zero.
      st_nxt.rdata = 32'h0000_0000;
      if (rd_acc)
      begin
         if (is_reg(PADDR, smc_pkg::STANDBY_MODE_CONTROL_OFS))
         begin
            st_nxt.rdata = {27'h0, st_r.low_power_in_standby, 1'b0, st_r.pin_state_select,
                            st_r.standby_request};
         end
         else if (is_reg(PADDR, smc_pkg::EXTENDED_STANDBY_CONTROL_OFS))
         begin
            st_nxt.rdata = {27'h0, st_r.flash_powerdown_select, st_r.bus_start_delay};
         end
         else if (is_reg(PADDR, smc_pkg::CLOCK_SELECT_OFS))
         begin
            st_nxt.rdata = {20'h0, st_r.rc_osc_enable, st_r.pll_enable, st_r.main_osc_enable,
                            st_r.sub_osc_enable, 2'h0, st_r.system_clock2_select, 2'h0,
                            st_r.system_clock1_select};
         end
         else if (is_reg(PADDR, smc_pkg::CLOCK_MONITOR_OFS))
         begin
            st_nxt.rdata = {25'h0, st_r.mode, 2'h0, st_r.system_clock1_monitor};
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Reset lands in RC Run with the low-power, pin and flash bits cleared.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         st_r                      <= '0;
         st_r.ext_sync             <= 2'h3;
         st_r.bus_start_delay      <= smc_pkg::BSD_RESET;
         st_r.rc_osc_enable        <= 1'b1;
         st_r.mode                 <= 3'(M_RUN);
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Bus start delay counter.
   smc_delay #(
      .CW     (12)
   ) u_delay (
      .CLK    (CLK),
      .RST_B  (RST_B),
      .start  (dly_start),
      .cycles (bsd_cycles(st_r.bus_start_delay)),
      .busy   (dly_busy)
   );

   // ----------------------------------------------------------------------
   // Clock, power and pin outputs
   // ----------------------------------------------------------------------
   // External reset overrides the clock outputs in every mode; Stop overrides the source selects.
   always_comb
   begin
      logic [1:0] src;
      logic       sub_mode;
      logic       stby;
      logic       deep;
      src      = st_r.system_clock1_monitor;
      sub_mode = (src == smc_pkg::SRC_SUB);
      stby     = (mode_q == M_SLEEP) || (mode_q == M_TIMER);
      deep     = (mode_q == M_TIMER) || (mode_q == M_STOP);

      CLK_CTRL.rc_osc_on               = (src == smc_pkg::SRC_RC) || st_r.rc_osc_enable
                                         || st_r.system_clock2_select == smc_pkg::SRC_RC;
      CLK_CTRL.rc_timer_run            = CLK_CTRL.rc_osc_on;
      CLK_CTRL.main_osc_on             = (src == smc_pkg::SRC_MAIN) || (src == smc_pkg::SRC_PLL)
                                         || st_r.main_osc_enable || st_r.pll_enable
                                         || st_r.system_clock2_select == smc_pkg::SRC_MAIN;
      CLK_CTRL.main_timer_run          = CLK_CTRL.main_osc_on;
      CLK_CTRL.pll_on                  = (src == smc_pkg::SRC_PLL) || st_r.pll_enable
                                         || st_r.system_clock2_select == smc_pkg::SRC_PLL;
      CLK_CTRL.sub_osc_on              = sub_mode || st_r.sub_osc_enable
                                         || st_r.system_clock2_select == smc_pkg::SRC_SUB;
      CLK_CTRL.sub_timer_run           = CLK_CTRL.sub_osc_on;
      CLK_CTRL.bus_clock_en            = (mode_q == M_RUN);
      CLK_CTRL.peripheral_clock_one_en = !deep && mode_q != M_WAKE;
      CLK_CTRL.peripheral_clock_two_en = CLK_CTRL.peripheral_clock_one_en;

      if (mode_q == M_STOP)
      begin
         CLK_CTRL = '0;
      end
      if (ext_rst)
      begin
         CLK_CTRL                = '0;
         CLK_CTRL.rc_osc_on      = 1'b1;
         CLK_CTRL.main_osc_on    = 1'b1;
         CLK_CTRL.main_timer_run = 1'b1;
      end

      // Low-power bit set forces mode A in Sleep and Timer.
      PWR_CTRL.low_power_a_voltage  = stby && (st_r.low_power_in_standby
                                      || !(CLK_CTRL.rc_osc_on || CLK_CTRL.main_osc_on));
      PWR_CTRL.regulator_high_power = (mode_q != M_STOP) && !PWR_CTRL.low_power_a_voltage;
      PWR_CTRL.pins_hiz             = deep && st_r.pin_state_select;
      PWR_CTRL.pins_hold            = deep && !st_r.pin_state_select;
      PWR_CTRL.port_input_block     = deep;
      // Power-down is lifted on wake, so the flash can reach its read state while the restart waits.
      PWR_CTRL.flash_powerdown      = st_r.flash_down && mode_q != M_RUN && mode_q != M_WAKE;
   end

   // Bus handshake and hold of the first core transfer after release.
   assign CORE_BUS_HOLD = dly_busy || (mode_q != M_RUN);
   assign PRDATA        = st_r.rdata;
   assign PREADY        = 1'b1;
   assign PSLVERR       = PSEL && PENABLE && !addr_ok;

endmodule : smc_ctrl

/* shared/smc_pkg.sv */
// Package for the standby mode controller: register offsets, field positions,
// reset values, mode encodings and carrier structs.
// Assumes a 32-bit APB slave with one aligned word per register.
package smc_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] STANDBY_MODE_CONTROL_OFS     = 12'h000;
   localparam logic [11:0] EXTENDED_STANDBY_CONTROL_OFS = 12'h004;
   localparam logic [11:0] CLOCK_SELECT_OFS             = 12'h008;
   localparam logic [11:0] CLOCK_MONITOR_OFS            = 12'h00c;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int LPSS_BIT  = 4;
   localparam int PSS_BIT   = 2;
   localparam int FPD_BIT   = 4;
   localparam int SC2_LSB   = 4;
   localparam int SCE_BIT   = 8;
   localparam int MCE_BIT   = 9;
   localparam int PCE_BIT   = 10;
   localparam int RCE_BIT   = 11;
   localparam int MODE_LSB  = 4;

   // ----------------------------------------------------------------------
   // Reset values and bus start delay limit
   // ----------------------------------------------------------------------
   localparam logic [3:0]  BSD_RESET      = 4'h1;
   localparam logic [11:0] CLKSEL_RESET   = 12'h800;
   localparam logic [11:0] BSD_CYCLES_MAX = 12'h7ff;

   // Clock sources, as held in the system clock select and monitor fields.
   typedef enum logic [1:0] {SRC_RC = 2'h0, SRC_MAIN = 2'h1, SRC_PLL = 2'h2, SRC_SUB = 2'h3} smc_src_type;

   // Standby request codes.
   typedef enum logic [1:0] {REQ_RUN = 2'h0, REQ_SLEEP = 2'h1, REQ_TIMER = 2'h2, REQ_STOP = 2'h3} smc_req_type;

   // Clock and power controls driven toward the clock generator.
   typedef struct packed {
      logic rc_osc_on;
      logic rc_timer_run;
      logic main_osc_on;
      logic main_timer_run;
      logic pll_on;
      logic sub_osc_on;
      logic sub_timer_run;
      logic bus_clock_en;
      logic peripheral_clock_one_en;
      logic peripheral_clock_two_en;
   } smc_clk_type;

   // Power and pin policy outputs.
   typedef struct packed {
      logic regulator_high_power;
      logic low_power_a_voltage;
      logic pins_hiz;
      logic pins_hold;
      logic port_input_block;
      logic flash_powerdown;
   } smc_pwr_type;

endpackage : smc_pkg

/* hdl/smc_delay.sv */
// Bus start delay counter used after standby release.
// Assumes it is clocked on the same clock as the controller.
`timescale 1ns/100ps
module smc_delay #(
   parameter int CW = 12
) (
   input  wire logic          CLK,     // System clock.
   input  wire logic          RST_B,   // Asynchronous reset, active low.
   input  wire logic          start,   // Pulse: load the count.
   input  wire logic [CW-1:0] cycles,  // Cycles to wait.
   output logic               busy     // High while counting.
);

   typedef struct packed {
      logic [CW-1:0] cnt;
   } smc_dly_state_type;

   smc_dly_state_type st_r;
   smc_dly_state_type st_nxt;

   // ----------------------------------------------------------------------
   // Countdown
   // ----------------------------------------------------------------------
   // A reload during a count restarts it, so a fresh release always waits fully.
   always_comb
   begin
      st_nxt = st_r;
      if (start)
      begin
         st_nxt.cnt = cycles;
      end
      else if (st_r.cnt != '0)
      begin
         st_nxt.cnt = st_r.cnt - CW'(1);
      end
   end

   // State register.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign busy = (st_r.cnt != '0);

endmodule : smc_delay

/* tb/smc_ctrl_asserts.sv */
// Checker on the standby mode controller top ports.
// Assumes it is bound to smc_ctrl and sees nothing but its ports.
`timescale 1ns/100ps
module smc_ctrl_chk (
   input wire logic                 CLK,          // Clock.
   input wire logic                 RST_B,        // Reset.
   input wire logic                 EXT_RST_B,    // Pin reset.
   input wire logic                 IRQ_WAKE,     // Wake.
   input wire logic                 FLASH_BUSY,   // Flash busy.
   input wire logic                 FLASH_READY,  // Flash ready.
   input wire logic                 PSEL,         // Select.
   input wire logic                 PENABLE,      // Enable.
   input wire logic                 PWRITE,       // Direction.
   input wire logic [11:0]          PADDR,        // Address.
   input wire logic [31:0]          PWDATA,       // Write data.
   input wire logic [31:0]          PRDATA,       // Read data.
   input wire logic                 PREADY,       // Ready.
   input wire logic                 PSLVERR,      // Error.
   input wire smc_pkg::smc_clk_type CLK_CTRL,     // Clocks.
   input wire smc_pkg::smc_pwr_type PWR_CTRL,     // Power.
   input wire logic                 CORE_BUS_HOLD // Bus hold.
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   // Quiet inputs for three edges so the wake synchroniser has settled low and the pin reset one high.
   sequence s_quiet;
      (!IRQ_WAKE && EXT_RST_B)[*3];
   endsequence
   sequence s_req(logic [1:0] c);
      s_quiet ##0 (PSEL && PENABLE && PWRITE && PADDR == 12'h000 && PWDATA[1:0] == c && !CORE_BUS_HOLD);
   endsequence
   a_stop_all_off: assert property (s_req(2'h3) |-> ##[1:2] CLK_CTRL == '0)
      else $error("clocks still running in stop");
   a_timer_periph_off: assert property (s_req(2'h2) |-> ##[1:2] CLK_CTRL[2:0] == 3'h0)
      else $error("timer left a clock running");
   a_sleep_bus_off: assert property (s_req(2'h1) |-> ##[1:2] CLK_CTRL[2:1] == 2'h1)
      else $error("sleep clock pattern wrong");
   a_ext_reset_pattern: assert property ((!EXT_RST_B)[*3] |-> CLK_CTRL == 10'h2c0)
      else $error("pin reset clock pattern wrong");
   a_reset_rc_run: assert property ($rose(RST_B) |-> CLK_CTRL[9] && CLK_CTRL[2] && PWR_CTRL == 6'h20)
      else $error("reset did not give rc run");
   a_pins_block_inputs: assert property ((PWR_CTRL.pins_hiz || PWR_CTRL.pins_hold)
      |-> PWR_CTRL.port_input_block && !CLK_CTRL.peripheral_clock_one_en)
      else $error("pin policy outside timer or stop");
   a_run_high_power: assert property (CLK_CTRL.bus_clock_en && CLK_CTRL.rc_osc_on
      |-> PWR_CTRL.regulator_high_power && !PWR_CTRL.low_power_a_voltage)
      else $error("regulator not high power in run");
   a_sleep_wake_run: assert property ((CLK_CTRL[2:1] == 2'h1 && !PWR_CTRL.flash_powerdown && IRQ_WAKE)[*3]
      |-> ##[1:3] CLK_CTRL.bus_clock_en)
      else $error("no wake from sleep");
   a_hold_after_wake: assert property ($rose(CLK_CTRL.bus_clock_en) && $past(EXT_RST_B, 4)
      |-> CORE_BUS_HOLD[*8])
      else $error("bus start delay too short");
endmodule : smc_ctrl_chk
bind smc_ctrl smc_ctrl_chk smc_ctrl_chk_i (.CLK(CLK), .RST_B(RST_B), .EXT_RST_B(EXT_RST_B), .IRQ_WAKE(IRQ_WAKE),
   .FLASH_BUSY(FLASH_BUSY), .FLASH_READY(FLASH_READY), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CLK_CTRL(CLK_CTRL),
   .PWR_CTRL(PWR_CTRL), .CORE_BUS_HOLD(CORE_BUS_HOLD));

/* tb/smc_far.sv */
// Far-side model: interrupt controller and flash macro.
// Assumes the bench raises wake and the block drives the power policy.
`timescale 1ns/100ps
module smc_far (
   input  wire logic                 CLK,  // Clock.
   input  wire logic                 wake, // Bench wake request.
   input  wire logic                 prog, // Bench flash program request.
   input  wire smc_pkg::smc_pwr_type pwr,  // Block power policy.
   output logic                      irq,  // Pending interrupt.
   output logic                      busy, // Flash program or erase.
   output logic                      ready // Flash read state.
);
   logic [3:0] cnt;
   initial irq = 1'h0;
   initial cnt = 4'h0;
   assign busy = prog;
   // The interrupt stays pending as long as the bench holds its request.
   always @(posedge CLK) irq <= wake;
   // Flash is slow to reach read state, so a wake must wait for it.
   always @(posedge CLK)
   begin
      if (pwr.flash_powerdown)
         cnt <= 4'h8;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
   assign ready = (cnt == 4'h0);
endmodule : smc_far

/* tb/testbench.sv */
// Self-checking bench for the standby mode controller.
// Assumes smc_ctrl, smc_far and the checker are compiled before it.
`timescale 1ns/100ps
module testbench;
   logic                 clk, rst_b, ext_rst_b, wake, psel, penable, pwrite;
   logic                 pready, pslverr, hold, irq, busy, fl_rdy, er, prog;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd;
   smc_pkg::smc_clk_type ck;
   smc_pkg::smc_pwr_type pw;
   int                   n_fail, cmp_count, n, hc;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d;} smc_row_type;
   // Read rows carry the expected value, write rows the data.
   smc_row_type rows[17] = '{'{1'h0, 12'h000, 32'h0}, '{1'h0, 12'h004, 32'h1}, '{1'h0, 12'h008, 32'h800},
      '{1'h0, 12'h00c, 32'h0}, '{1'h1, 12'h000, 32'h14}, '{1'h0, 12'h000, 32'h14}, '{1'h1, 12'h000, 32'h0},
      '{1'h0, 12'h000, 32'h0}, '{1'h1, 12'h004, 32'h12}, '{1'h0, 12'h004, 32'h12}, '{1'h1, 12'h004, 32'h1},
      '{1'h1, 12'h008, 32'ha01}, '{1'h0, 12'h00c, 32'h1}, '{1'h0, 12'h008, 32'ha01}, '{1'h1, 12'h008, 32'h800},
      '{1'h0, 12'h00c, 32'h0}, '{1'h0, 12'h010, 32'h0}};
   logic [31:0] ex[4] = '{32'h0, 32'h1, 32'h800, 32'h0};
   smc_ctrl smc_ctrl_i (.CLK(clk), .RST_B(rst_b), .EXT_RST_B(ext_rst_b), .IRQ_WAKE(irq), .FLASH_BUSY(busy),
      .FLASH_READY(fl_rdy), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CLK_CTRL(ck), .PWR_CTRL(pw), .CORE_BUS_HOLD(hold));
   smc_far smc_far_i (.CLK(clk), .wake(wake), .prog(prog), .pwr(pw), .irq(irq), .busy(busy), .ready(fl_rdy));
   task automatic finish_test;
      if (n_fail == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; read data and error are taken at the edge where ready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1)
      begin
         n_fail++;
         finish_test;
      end
   endtask : apb
   task automatic enter(input logic [31:0] d);
      apb(1'h1, 12'h000, d);
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : enter
   // Raise a wake and count edges where the bus clock runs but the core is held.
   task automatic wake_up;
      @(posedge clk);
      wake <= 1'h1;
      hc = 0;
      n = 0;
      while (!(ck.bus_clock_en === 1'h1 && hold === 1'h0) && n < 3000)
      begin
         @(negedge clk);
         n++;
         if (ck.bus_clock_en === 1'h1 && hold === 1'h1)
            hc++;
      end
      @(posedge clk);
      wake <= 1'h0;
      if (n == 3000)
      begin
         n_fail++;
         finish_test;
      end
   endtask : wake_up
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      {rst_b, wake, prog, psel, penable, pwrite, paddr, pwdata, n_fail, cmp_count} = '0;
      ext_rst_b = 1'h1;
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      repeat (2) @(posedge clk);
      foreach (rows[i])
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk(32'(er), 32'(rows[i].a > smc_pkg::CLOCK_MONITOR_OFS));
         if (!rows[i].w)
            chk(rd, rows[i].d);
      end
      enter(32'h1);
      chk(32'(ck[2:1]), 32'h1);
      wake_up;
      chk(32'(hc), 32'd16);
      apb(1'h0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      enter(32'h6);
      chk(32'(ck[2:0]), 32'h0);
      chk(32'({pw.pins_hiz, pw.port_input_block}), 32'h3);
      enter(32'h4);
      chk(32'(ck.peripheral_clock_one_en), 32'h0);
      wake_up;
      apb(1'h1, 12'h008, 32'ha01);
      enter(32'h3);
      chk(32'(ck), 32'h0);
      chk(32'(pw.pins_hold), 32'h1);
      wake_up;
      apb(1'h0, 12'h00c, 32'h0);
      chk(rd, 32'h1);
      apb(1'h1, 12'h008, 32'h800);
      wake <= 1'h1;
      apb(1'h1, 12'h000, 32'h1);
      apb(1'h0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      chk(32'(ck.bus_clock_en), 32'h1);
      wake <= 1'h0;
      apb(1'h1, 12'h004, 32'h18);
      enter(32'h11);
      chk(32'({pw.low_power_a_voltage, pw.flash_powerdown}), 32'h3);
      wake_up;
      chk(32'(pw.regulator_high_power), 32'h1);
      apb(1'h1, 12'h000, 32'h0);
      ext_rst_b <= 1'h0;
      repeat (4) @(negedge clk);
      chk(32'(ck), 32'h2c0);
      @(posedge clk);
      ext_rst_b <= 1'h1;
      apb(1'h1, 12'h008, 32'ha01);
      prog <= 1'h1;
      apb(1'h1, 12'h004, 32'h10);
      enter(32'h7);
      chk(32'(pw.flash_powerdown), 32'h0);
      @(posedge clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      for (int i = 0; i < 4; i++)
      begin
         apb(1'h0, 12'(4 * i), 32'h0);
         chk(rd, ex[i]);
      end
      finish_test;
   end
endmodule : testbench
